// file: hw/port3_io.sv
// Purpose: Six-line port with comparator, timer and serial pin routing
// Assumes: Pins and peripheral signals synchronous to i_clk
// Notes: Register access over Avalon-MM; one wait state per access
//
// Behaviour
// - Six lines: lines 1-3 input only, lines 4-6 push-pull outputs.
// - Input lines 1-3 get no hold latch; others are held at a level.
// - Mode bit D1 selects analogue: lines 1,2 comparator inputs, line 3 reference.
// - Lines 1,2 interrupt on falling, rising or both edges per bits 7:6.
// - Line 3 interrupts on falling edge only, in digital mode only.
// - Lines 1,2 interrupt in both modes; line 1 feeds timer in both.
// - Config D0 set puts comparator results on lines 4,5; clear restores.
// - Timer one uses line 1 as input and line 6 as output.
// - Serial enabled: line 4 is bidirectional clock, line 5 slave select.
// - Digital mode: line 3 readable in data register and an interrupt source.
// - Reduced-emission drive set per port and oscillator in config register.
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/1ps
module port3_io
    import port3_pkg::*;
(
    input wire logic i_clk,                     // System clock, 50 MHz
    input wire logic i_reset,                   // Synchronous reset, active high
    input wire logic [ADDR_W-1:0] i_address,    // Avalon byte address
    input wire logic i_read,                    // Avalon read
    input wire logic i_write,                   // Avalon write
    input wire logic [DATA_W-1:0] i_writedata,  // Avalon write data
    output logic [DATA_W-1:0] o_readdata,       // Avalon read data
    output logic o_waitrequest,                 // Avalon wait request
    input wire logic i_port_in_line1,           // Input line 1 pin
    input wire logic i_port_in_line2,           // Input line 2 pin
    input wire logic i_port_in_line3_ref,       // Input line 3 pin
    input wire logic i_port_out_line4,          // Line 4 pin level (serial clock in)
    input wire logic i_port_out_line5,          // Line 5 pin level (slave select in)
    output logic o_port_out_line4,              // Line 4 drive value
    output logic o_port_out_line4_oe,           // Line 4 output enable
    output logic o_port_out_line5,              // Line 5 drive value
    output logic o_port_out_line5_oe,           // Line 5 output enable
    output logic o_port_out_line6,              // Line 6 drive value
    input wire logic i_comp1_result,            // Comparator 1 result
    input wire logic i_comp2_result,            // Comparator 2 result
    output logic o_comp_enable,                 // Comparators and analogue path on
    input wire logic i_timer1_out,              // Timer one output signal
    output logic o_timer1_in,                   // Timer one external input
    input wire logic i_serial_enable,           // Serial interface enabled
    input wire logic i_serial_master,           // Serial interface in master mode
    input wire logic i_serial_clock_out,        // Serial clock from master logic
    output logic o_serial_clock_pin,            // Serial clock seen on line 4
    output logic o_slave_select,                // Slave select seen on line 5
    output logic o_low_emi_port2,               // Reduced-emission drive, port 2
    output logic o_low_emi_port3,               // Reduced-emission drive, port 3
    output logic o_low_emi_osc,                 // Reduced-emission oscillator
    output logic o_irq                          // Interrupt, level, active high
);

    ////////////////////////////////////////////////////////////////////////
    // Register bus

    logic [7:0] mode_reg, mode_next;
    logic [7:0] cfg_reg, cfg_next;
    logic [7:0] irq_ctrl_reg, irq_ctrl_next;
    logic [2:0] out_data_reg, out_data_next;
    logic [2:0] mask_reg, mask_next;
    logic wait_reg, wait_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic [2:0] status;
    logic [2:0] clear_w1c;
    logic [2:0] in_lines;
    logic [2:0] rise, fall;
    logic [2:0] events;
    logic [7:0] data_view;
    logic analog_mode;
    logic req, wr_take;

    assign req = i_read | i_write;
    // Write lands on the edge that the master also sees waitrequest low
    assign wr_take = i_write & ~wait_reg;
    assign analog_mode = mode_reg[MODE_ANALOG_BIT];
    assign in_lines = {i_port_in_line3_ref, i_port_in_line2, i_port_in_line1};

    always_comb begin
        data_view = 8'h00;
        // Lines are read raw; with no hold latch a floating pin reads as whatever it is
        if (analog_mode) begin
            data_view[1:0] = {i_comp2_result, i_comp1_result};
        end else begin
            data_view[2:0] = in_lines;
        end
        data_view[DATA_OUT_LSB +: 3] = {o_port_out_line6, o_port_out_line5, o_port_out_line4};
    end

    // Read data load in the wait cycle, so they already stand at the accept edge
    always_comb begin
        wait_next = ~(req & wait_reg);
        rdata_next = rdata_reg;
        if (i_read & wait_reg) begin
            unique case (i_address)
                ADDR_MODE: rdata_next = {24'h000000, mode_reg};
                ADDR_CONFIG: rdata_next = {24'h000000, cfg_reg};
                ADDR_IRQ_CTRL: rdata_next = {24'h000000, irq_ctrl_reg};
                ADDR_DATA: rdata_next = {24'h000000, data_view};
                ADDR_STATUS: rdata_next = {29'h00000000, status};
                ADDR_MASK: rdata_next = {29'h00000000, mask_reg};
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    always_comb begin
        mode_next = mode_reg;
        cfg_next = cfg_reg;
        irq_ctrl_next = irq_ctrl_reg;
        out_data_next = out_data_reg;
        mask_next = mask_reg;
        clear_w1c = 3'h0;
        if (wr_take) begin
            unique case (i_address)
                ADDR_MODE: mode_next = i_writedata[7:0];
                // Reserved config bits stay one whatever is written
                ADDR_CONFIG: cfg_next = i_writedata[7:0] | CFG_RESERVED_MASK;
                ADDR_IRQ_CTRL: irq_ctrl_next = i_writedata[7:0];
                ADDR_DATA: out_data_next = i_writedata[DATA_OUT_LSB +: 3];
                ADDR_STATUS: clear_w1c = i_writedata[2:0];
                ADDR_MASK: mask_next = i_writedata[2:0];
                default: mode_next = mode_reg;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mode_reg <= MODE_RESET;
            cfg_reg <= CFG_RESET;
            irq_ctrl_reg <= IRQ_CTRL_RESET;
            out_data_reg <= OUT_DATA_RESET;
            mask_reg <= MASK_RESET;
            wait_reg <= 1'b1;
            rdata_reg <= 32'h00000000;
        end else begin
            mode_reg <= mode_next;
            cfg_reg <= cfg_next;
            irq_ctrl_reg <= irq_ctrl_next;
            out_data_reg <= out_data_next;
            mask_reg <= mask_next;
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    assign o_waitrequest = wait_reg;
    assign o_readdata = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt events

    line_edge_detect #(.WIDTH(3)) u_edges (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_lines(in_lines),
        .o_rise(rise),
        .o_fall(fall)
    );

    logic [1:0] edge_sel;
    assign edge_sel = irq_ctrl_reg[EDGE_SEL_LSB +: 2];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_line_irq
            // Digital edges stay live in analogue mode too
            assign events[g] = (edge_sel == EDGE_FALL) ? fall[g] :
                               (edge_sel == EDGE_RISE) ? rise[g] :
                               (rise[g] | fall[g]);
        end
    endgenerate

    // Line 3 is the comparator reference in analogue mode, so no interrupt then
    assign events[2] = fall[2] & ~analog_mode;

    sticky_flags #(.WIDTH(3)) u_status (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_set(events),
        .i_clear(clear_w1c),
        .o_flags(status)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin routing, all outputs registered

    logic l4_reg, l4_next, l4_oe_reg, l4_oe_next;
    logic l5_reg, l5_next, l5_oe_reg, l5_oe_next;
    logic l6_reg, l6_next;
    logic comp_en_reg, tin_reg, sck_reg, ss_reg;
    logic emi2_reg, emi3_reg, emio_reg, irq_reg;
    logic [7:0] misc_next;

    always_comb begin
        // Serial pins outrank comparator outputs, which outrank port data
        l4_next = out_data_reg[0];
        l4_oe_next = 1'b1;
        l5_next = out_data_reg[1];
        l5_oe_next = 1'b1;
        if (cfg_reg[CFG_COMP_OUT_BIT]) begin
            l4_next = i_comp1_result;
            l5_next = i_comp2_result;
        end
        if (i_serial_enable) begin
            l4_next = i_serial_clock_out;
            l4_oe_next = i_serial_master;
            if (!i_serial_master) begin
                l5_oe_next = 1'b0;
            end
        end
        l6_next = mode_reg[MODE_TIMER_OUT_BIT] ? i_timer1_out : out_data_reg[2];
        misc_next = {
            |(status & mask_reg),
            ~cfg_reg[CFG_STD_OSC_BIT],
            ~cfg_reg[CFG_STD_PORT3_BIT],
            ~cfg_reg[CFG_STD_PORT2_BIT],
            i_port_out_line5,
            i_port_out_line4,
            i_port_in_line1,
            analog_mode
        };
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            l4_reg <= 1'b0;
            l4_oe_reg <= 1'b1;
            l5_reg <= 1'b0;
            l5_oe_reg <= 1'b1;
            l6_reg <= 1'b0;
            {irq_reg, emio_reg, emi3_reg, emi2_reg, ss_reg, sck_reg, tin_reg, comp_en_reg}
                <= 8'h00;
        end else begin
            l4_reg <= l4_next;
            l4_oe_reg <= l4_oe_next;
            l5_reg <= l5_next;
            l5_oe_reg <= l5_oe_next;
            l6_reg <= l6_next;
            {irq_reg, emio_reg, emi3_reg, emi2_reg, ss_reg, sck_reg, tin_reg, comp_en_reg}
                <= misc_next;
        end
    end

    assign o_port_out_line4 = l4_reg;
    assign o_port_out_line4_oe = l4_oe_reg;
    assign o_port_out_line5 = l5_reg;
    assign o_port_out_line5_oe = l5_oe_reg;
    assign o_port_out_line6 = l6_reg;
    assign o_comp_enable = comp_en_reg;
    assign o_timer1_in = tin_reg;
    assign o_serial_clock_pin = sck_reg;
    assign o_slave_select = ss_reg;
    assign o_low_emi_port2 = emi2_reg;
    assign o_low_emi_port3 = emi3_reg;
    assign o_low_emi_osc = emio_reg;
    assign o_irq = irq_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    bus_answer_a: assert property (req && wait_reg |=> !o_waitrequest)
        else $error("Request not answered in one wait cycle");
    analog_sel_a: assert property (##1 o_comp_enable == $past(mode_reg[1]))
        else $error("Comparator enable does not follow mode bit");
    edge_rise_a: assert property (rise[0] && edge_sel == 2'h1 |=> status[0])
        else $error("Rising edge on line 1 not flagged");
    edge_fall_a: assert property (fall[1] && edge_sel == 2'h0 && !rise[1] |=> status[1])
        else $error("Falling edge on line 2 not flagged");
    line3_digital_a: assert property (fall[2] && !analog_mode |=> status[2])
        else $error("Line 3 falling edge lost in digital mode");
    line3_analog_a: assert property (analog_mode && !status[2] |=> !status[2])
        else $error("Line 3 interrupt raised in analogue mode");
    comp_out_a: assert property (cfg_reg[CFG_COMP_OUT_BIT] && !i_serial_enable
        |=> o_port_out_line4 == $past(i_comp1_result))
        else $error("Comparator result missing on line 4");
    timer_in_a: assert property (##1 o_timer1_in == $past(i_port_in_line1))
        else $error("Timer input does not follow line 1");
    slave_sel_a: assert property (i_serial_enable && !i_serial_master
        |=> !o_port_out_line5_oe && !o_port_out_line4_oe)
        else $error("Slave mode still drives lines 4 or 5");
    data_read_a: assert property (i_read && wait_reg && !analog_mode
        && i_address == ADDR_DATA |=> o_readdata[2:0] == $past(in_lines))
        else $error("Digital read of lines 1-3 wrong");
    emi_cfg_a: assert property (##1 o_low_emi_port3 == !$past(cfg_reg[6]))
        else $error("Port 3 emission setting not applied");
    analog_edge_a: assert property (analog_mode && rise[0] && edge_sel == EDGE_RISE
        |=> status[0])
        else $error("Line 1 edge lost in analogue mode");
    irq_level_a: assert property ((status & mask_reg) != 3'h0 |=> o_irq)
        else $error("Unmasked event did not raise the interrupt");

    irq_fire_c: cover property (status[0] && mask_reg[0] ##1 o_irq);
    line3_irq_c: cover property (fall[2] && !analog_mode);
    serial_on_c: cover property (i_serial_enable && i_serial_master);
    comp_route_c: cover property (cfg_reg[0] && analog_mode);
    timer_route_c: cover property (mode_reg[MODE_TIMER_OUT_BIT] && analog_mode);
endmodule

// file: hw/port3_pkg.sv
// Purpose: Shared constants for the six-line port block
// Assumes: 32-bit Avalon-MM data, byte addresses, one register per word
// Notes: Registers hold up to 8 bits in the low byte (status and mask 3); upper bits read as zero
package port3_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam logic [4:0] ADDR_MODE = 5'h00;
    localparam logic [4:0] ADDR_CONFIG = 5'h04;
    localparam logic [4:0] ADDR_IRQ_CTRL = 5'h08;
    localparam logic [4:0] ADDR_DATA = 5'h0C;
    localparam logic [4:0] ADDR_STATUS = 5'h10;
    localparam logic [4:0] ADDR_MASK = 5'h14;
    // Mode register fields
    localparam int MODE_TIMER_OUT_BIT = 0;
    localparam int MODE_ANALOG_BIT = 1;
    localparam logic [7:0] MODE_RESET = 8'h00;
    // Config register fields
    localparam int CFG_COMP_OUT_BIT = 0;
    localparam int CFG_STD_PORT2_BIT = 5;
    localparam int CFG_STD_PORT3_BIT = 6;
    localparam int CFG_STD_OSC_BIT = 7;
    localparam logic [7:0] CFG_RESERVED_MASK = 8'h1E;
    localparam logic [7:0] CFG_RESET = 8'hFE;
    // Edge select in interrupt control bits 7:6
    localparam int EDGE_SEL_LSB = 6;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [7:0] IRQ_CTRL_RESET = 8'h00;
    // Data register layout
    localparam int DATA_OUT_LSB = 4;
    localparam logic [2:0] OUT_DATA_RESET = 3'h0;
    localparam logic [2:0] STATUS_RESET = 3'h0;
    localparam logic [2:0] MASK_RESET = 3'h0;
endpackage

// file: hw/line_edge_detect.sv
// Purpose: Rising and falling edge pulses for a group of input lines
// Assumes: Inputs synchronous to i_clk
// Notes: Pulses are combinational, valid for one cycle
`timescale 1ns/1ps
module line_edge_detect #(
    parameter int WIDTH = 3
) (
    input wire logic i_clk,               // System clock
    input wire logic i_reset,             // Synchronous reset, active high
    input wire logic [WIDTH-1:0] i_lines, // Sampled lines
    output logic [WIDTH-1:0] o_rise,      // Rising edge pulse
    output logic [WIDTH-1:0] o_fall       // Falling edge pulse
);
    logic [WIDTH-1:0] prev_reg;
    logic [WIDTH-1:0] prev_next;

    always_comb begin
        prev_next = i_lines;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            // Follow the pins through reset so a line idling high gives no false edge
            prev_reg <= prev_next;
        end else begin
            prev_reg <= prev_next;
        end
    end

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_edge
            // No edges reported while reset is asserted
            assign o_rise[g] = ~prev_reg[g] & i_lines[g] & ~i_reset;
            assign o_fall[g] = prev_reg[g] & ~i_lines[g] & ~i_reset;
        end
    endgenerate
endmodule

// file: hw/sticky_flags.sv
// Purpose: Sticky event flags cleared by writing one
// Assumes: Clear and set may arrive in the same cycle
// Notes: Set wins over clear so no event is lost
`timescale 1ns/1ps
module sticky_flags #(
    parameter int WIDTH = 3
) (
    input wire logic i_clk,               // System clock
    input wire logic i_reset,             // Synchronous reset, active high
    input wire logic [WIDTH-1:0] i_set,   // Event pulses
    input wire logic [WIDTH-1:0] i_clear, // Write-one-to-clear strobes
    output logic [WIDTH-1:0] o_flags      // Flag state
);
    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    always_comb begin
        flags_next = (flags_reg & ~i_clear) | i_set;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= flags_next;
        end
    end

    assign o_flags = flags_reg;
endmodule

// file: verif/board_model.sv
// Purpose: Board side of port lines 4 and 5
// Assumes: The board drives a line only while the port releases it
// Notes: No pull resistors; a released line shows the board level
`timescale 1ns/1ps
module board_model (
    input wire logic i_drive4, // Port drive, line 4
    input wire logic i_oe4,    // Port enable, line 4
    input wire logic i_drive5, // Port drive, line 5
    input wire logic i_oe5,    // Port enable, line 5
    input wire logic i_ext_sclk, // Board serial clock
    input wire logic i_ext_ss, // Board slave select
    output logic o_line4,      // Resolved level, line 4
    output logic o_line5       // Resolved level, line 5
);
    // Line 4 turns round only when the serial unit is a slave
    assign o_line4 = i_oe4 ? i_drive4 : i_ext_sclk;
    assign o_line5 = i_oe5 ? i_drive5 : i_ext_ss;
endmodule

// file: verif/testbench.sv
// Purpose: Self-checking bench for the six-line port block
// Assumes: One wait state per bus access, outputs registered
// Notes: Bus answers are taken at the rising edge; steady outputs on the falling edge
`timescale 1ns/1ps
module testbench;
    import port3_pkg::*;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic rd_s = 1'b0, wr_s = 1'b0, waitreq;
    logic [DATA_W-1:0] wdata = '0, rdata_bus, rdata;
    logic l1 = 1'b0, l2 = 1'b0, l3 = 1'b0, c1 = 1'b0, c2 = 1'b0, tmr_out = 1'b0;
    logic ser_en = 1'b0, ser_m = 1'b0, ser_clk = 1'b0, ext_sclk = 1'b0, ext_ss = 1'b1;
    logic pin4, pin5, d4, oe4, d5, oe5, d6, comp_en, tmr_in, sclk_pin, ss, emi2, emi3, emio, irq;
    int bad_count = 0;
    int compares = 0;

    port3_io port3_io_inst (.i_clk(i_clk), .i_reset(i_reset), .i_address(addr),
        .i_read(rd_s), .i_write(wr_s), .i_writedata(wdata), .o_readdata(rdata_bus),
        .o_waitrequest(waitreq), .i_port_in_line1(l1), .i_port_in_line2(l2),
        .i_port_in_line3_ref(l3), .i_port_out_line4(pin4), .i_port_out_line5(pin5),
        .o_port_out_line4(d4), .o_port_out_line4_oe(oe4), .o_port_out_line5(d5),
        .o_port_out_line5_oe(oe5), .o_port_out_line6(d6), .i_comp1_result(c1),
        .i_comp2_result(c2), .o_comp_enable(comp_en), .i_timer1_out(tmr_out),
        .o_timer1_in(tmr_in), .i_serial_enable(ser_en), .i_serial_master(ser_m),
        .i_serial_clock_out(ser_clk), .o_serial_clock_pin(sclk_pin), .o_slave_select(ss),
        .o_low_emi_port2(emi2), .o_low_emi_port3(emi3), .o_low_emi_osc(emio), .o_irq(irq));

    board_model board_model_inst (.i_drive4(d4), .i_oe4(oe4), .i_drive5(d5), .i_oe5(oe5),
        .i_ext_sclk(ext_sclk), .i_ext_ss(ext_ss), .o_line4(pin4), .o_line5(pin5));

    always #10 i_clk = ~i_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("Compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request stands until the rising edge that samples waitrequest low; data taken there
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        logic w;
        int n;
        w = 1'b1;
        n = 0;
        @(posedge i_clk);
        addr <= a;
        rd_s <= ~wr;
        wr_s <= wr;
        wdata <= d;
        while (w && n < 20) begin
            @(posedge i_clk);
            w = waitreq;
            rdata = rdata_bus;
            n++;
        end
        rd_s <= 1'b0;
        wr_s <= 1'b0;
        if (w) begin
            bad_count++;
            finish_test();
        end
    endtask

    task automatic wreg(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(rdata, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge i_clk);
        @(negedge i_clk);
    endtask

    task automatic pins(input logic [2:0] v);
        @(posedge i_clk);
        l1 <= v[0];
        l2 <= v[1];
        l3 <= v[2];
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_regs();
        check({oe4, oe5, irq}, 3'h6);
        check({emio, emi3, emi2}, 3'h0);
        rchk(ADDR_MODE, 32'h0);
        rchk(ADDR_CONFIG, 32'hFE);
        rchk(ADDR_IRQ_CTRL, 32'h0);
        rchk(ADDR_STATUS, 32'h0);
        rchk(ADDR_MASK, 32'h0);
        wreg(5'h18, 32'hFF);
        rchk(5'h18, 32'h0);
        // Each drive option must move alone
        for (int i = 0; i < 3; i++) begin
            wreg(ADDR_CONFIG, 32'hFE & ~(32'h20 << i));
            settle(2);
            check({emio, emi3, emi2}, 3'h1 << i);
        end
        wreg(ADDR_CONFIG, 32'h0);
        rchk(ADDR_CONFIG, 32'h1E);
        wreg(ADDR_CONFIG, 32'hFE);
    endtask

    task automatic test_digital();
        for (int v = 0; v < 8; v++) begin
            pins(v[2:0]);
            settle(2);
            rchk(ADDR_DATA, {29'h0, v[2:0]});
        end
    endtask

    task automatic test_analog();
        wreg(ADDR_MODE, 32'h2);
        settle(2);
        check(comp_en, 1'b1);
        for (int v = 0; v < 4; v++) begin
            @(posedge i_clk);
            c1 <= v[0];
            c2 <= v[1];
            settle(2);
            rchk(ADDR_DATA, {30'h0, v[1:0]});
        end
        wreg(ADDR_MODE, 32'h0);
        settle(2);
        check(comp_en, 1'b0);
    endtask

    // Every edge code in both modes; line 3 falls with the others
    task automatic test_edges();
        for (int m = 0; m < 2; m++) begin
            wreg(ADDR_MODE, m * 2);
            for (int code = 0; code < 4; code++) begin
                wreg(ADDR_IRQ_CTRL, code << EDGE_SEL_LSB);
                pins(3'h0);
                settle(2);
                wreg(ADDR_STATUS, 32'h7);
                pins(3'h7);
                settle(2);
                rchk(ADDR_STATUS, (code != 0) ? 32'h3 : 32'h0);
                wreg(ADDR_STATUS, 32'h7);
                pins(3'h0);
                settle(2);
                rchk(ADDR_STATUS, {29'h0, m == 0, (code != 1) ? 2'h3 : 2'h0});
            end
        end
        wreg(ADDR_MODE, 32'h0);
        wreg(ADDR_IRQ_CTRL, 32'h0);
    endtask

    task automatic test_irq();
        wreg(ADDR_STATUS, 32'h7);
        pins(3'h7);
        settle(2);
        pins(3'h0);
        settle(2);
        check(irq, 1'b0);
        wreg(ADDR_MASK, 32'h1);
        settle(2);
        check(irq, 1'b1);
        wreg(ADDR_STATUS, 32'h1);
        settle(2);
        check(irq, 1'b0);
        rchk(ADDR_STATUS, 32'h6);
        wreg(ADDR_MASK, 32'h4);
        settle(2);
        check(irq, 1'b1);
        wreg(ADDR_STATUS, 32'h6);
    endtask

    task automatic test_outputs();
        wreg(ADDR_DATA, 32'h50);
        settle(2);
        check({d6, d5, oe5, d4, oe4}, 5'h17);
        rchk(ADDR_DATA, 32'h50);
        wreg(ADDR_CONFIG, 32'hFF);
        for (int v = 1; v < 3; v++) begin
            @(posedge i_clk);
            c1 <= v[0];
            c2 <= v[1];
            settle(2);
            check({d5, d4}, v[1:0]);
        end
        wreg(ADDR_CONFIG, 32'hFE);
        settle(2);
        check({d5, d4}, 2'h1);
        // Timer path must hold in digital and analogue mode
        for (int m = 1; m < 4; m += 2) begin
            wreg(ADDR_MODE, m);
            for (int t = 0; t < 2; t++) begin
                @(posedge i_clk);
                tmr_out <= t[0];
                l1 <= t[0];
                settle(2);
                check({d6, tmr_in}, {t[0], t[0]});
            end
        end
        wreg(ADDR_MODE, 32'h0);
    endtask

    task automatic test_serial();
        wreg(ADDR_CONFIG, 32'hFF);
        @(posedge i_clk);
        ser_en <= 1'b1;
        ser_m <= 1'b1;
        for (int t = 0; t < 2; t++) begin
            @(posedge i_clk);
            ser_clk <= t[0];
            settle(3);
            check({oe4, d4, sclk_pin}, {1'b1, t[0], t[0]});
        end
        @(posedge i_clk);
        ser_m <= 1'b0;
        for (int t = 0; t < 2; t++) begin
            @(posedge i_clk);
            ext_sclk <= t[0];
            ext_ss <= ~t[0];
            settle(3);
            check({oe4, oe5, sclk_pin, ss}, {2'h0, t[0], ~t[0]});
        end
        @(posedge i_clk);
        ser_en <= 1'b0;
        wreg(ADDR_CONFIG, 32'hFE);
        settle(2);
        check({oe4, oe5}, 2'h3);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        settle(1);
        test_regs();
        test_digital();
        test_analog();
        test_edges();
        test_irq();
        test_outputs();
        test_serial();
        finish_test();
    end

    initial begin
        repeat (100000) @(posedge i_clk);
        bad_count++;
        finish_test();
    end
endmodule
